// *** hdl/swl_pkg.sv ***
package swl_pkg;
  // Clock rate
  localparam int CLK_MHZ = 125;
  // Timing figures in microseconds
  localparam int RESET_LOW_US = 480;
  localparam int PRES_WAIT_US = 30;
  localparam int PRES_LOW_US = 120;
  localparam int SLOT_US = 70;
  localparam int REC_US = 2;
  localparam int WR1_LOW_US = 6;
  localparam int RD_LOW_US = 2;
  localparam int MST_SAMPLE_US = 12;
  localparam int SLV_SAMPLE_US = 30;
  localparam int RD_HOLD_US = 15;
  localparam int PRES_WIN_US = 300;
  localparam int RESET_DET_US = 400;
  localparam int SPU_DELAY_US = 5;
  // Cycle counts
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
  localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
  localparam int REC_CYC = REC_US * CLK_MHZ;
  localparam int WR1_LOW_CYC = WR1_LOW_US * CLK_MHZ;
  localparam int RD_LOW_CYC = RD_LOW_US * CLK_MHZ;
  localparam int MST_SAMPLE_CYC = MST_SAMPLE_US * CLK_MHZ;
  localparam int SLV_SAMPLE_CYC = SLV_SAMPLE_US * CLK_MHZ;
  localparam int RD_HOLD_CYC = RD_HOLD_US * CLK_MHZ;
  localparam int PRES_WIN_CYC = PRES_WIN_US * CLK_MHZ;
  localparam int RESET_DET_CYC = RESET_DET_US * CLK_MHZ;
  localparam int SPU_DELAY_CYC = SPU_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 17;
  // Host operation codes
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  // Function commands
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_RECALL = 8'hb8;
  localparam logic [7:0] CMD_READ_PAD = 8'hbe;
  localparam logic [7:0] CMD_READ_PWR = 8'hb4;
  localparam logic [7:0] CMD_COPY = 8'h48;
  localparam logic [7:0] CMD_MATCH = 8'h55;
endpackage : swl_pkg

// *** hdl/swl_link_if.sv ***
`timescale 1ns/1ps
interface swl_link_if;
  logic host_pull; // Host pulls line low
  logic dev_pull; // Device pulls line low
  logic line; // Resolved line level
  assign line = ~(host_pull | dev_pull);
  modport host (output host_pull, input line);
  modport dev (output dev_pull, input line);
endinterface : swl_link_if

// *** hdl/swl_sync.sv ***
`timescale 1ns/1ps
module swl_sync (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic d_i, // Raw line
  output logic q_o // Filtered line
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Three stage sampler, accept once stages two and three agree
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      q_o <= 1'b1;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) q_o <= s3_q;
    end
  end
endmodule : swl_sync

// *** hdl/swl_dev.sv ***
`timescale 1ns/1ps
module swl_dev (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Async reset
  swl_link_if.dev link, // Line side
  input wire logic busy_i, // Operation in progress
  input wire logic parasite_i, // Line powered device
  input wire logic tx_bit_i, // Next bit to send
  output logic tx_take_o, // Bit sent pulse
  output logic rx_valid_o, // Bit received pulse
  output logic rx_bit_o, // Received bit
  output logic present_o // Presence sent pulse
);
  typedef enum logic [2:0] {D_IDLE, D_RST, D_PWAIT, D_PLOW, D_SLOT, D_REL} swl_dstate_type;
  swl_dstate_type st_q;
  logic [swl_pkg::CNT_W-1:0] cnt_q;
  logic line_s;
  logic line_d1_q;
  logic send_q;
  logic rd_mode_q;
  logic [7:0] byte_q;
  logic [2:0] bit_q;
  logic fall;
  logic [7:0] cmd_d;

  swl_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(link.line),
    .q_o(line_s)
  );

  assign fall = line_d1_q & ~line_s;
  assign cmd_d = {rx_bit_o, byte_q[7:1]};

  // Slot state machine
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= D_IDLE;
      cnt_q <= '0;
      line_d1_q <= 1'b1;
      link.dev_pull <= 1'b0;
      tx_take_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_bit_o <= 1'b0;
      present_o <= 1'b0;
      send_q <= 1'b0;
    end else begin
      line_d1_q <= line_s;
      tx_take_o <= 1'b0;
      rx_valid_o <= 1'b0;
      present_o <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        D_IDLE: begin
          link.dev_pull <= 1'b0;
          if (fall) begin
            st_q <= D_SLOT;
            cnt_q <= '0;
            send_q <= rd_mode_q & ~(busy_i ? 1'b0 : tx_bit_i) ;
          end
        end
        D_SLOT: begin
          // One bit per slot; read zero pulled, write sampled mid window
          link.dev_pull <= send_q & (cnt_q < swl_pkg::CNT_W'(swl_pkg::RD_HOLD_CYC));
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::SLV_SAMPLE_CYC)) begin
            if (rd_mode_q) tx_take_o <= 1'b1;
            else begin
              rx_valid_o <= 1'b1;
              rx_bit_o <= line_s;
            end
          end
          if (line_s && cnt_q > swl_pkg::CNT_W'(swl_pkg::SLV_SAMPLE_CYC)) st_q <= D_IDLE;
          if (!line_s && cnt_q == swl_pkg::CNT_W'(swl_pkg::RESET_DET_CYC)) st_q <= D_RST;
        end
        D_RST: begin
          link.dev_pull <= 1'b0;
          if (line_s) begin
            st_q <= D_PWAIT;
            cnt_q <= '0;
          end
        end
        D_PWAIT: begin
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::PRES_WAIT_CYC)) begin
            st_q <= D_PLOW;
            cnt_q <= '0;
            link.dev_pull <= 1'b1;
          end
        end
        D_PLOW: begin
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::PRES_LOW_CYC)) begin
            st_q <= D_REL;
            link.dev_pull <= 1'b0;
            present_o <= 1'b1;
          end
        end
        D_REL: begin
          if (line_s) st_q <= D_IDLE;
        end
        default: st_q <= D_IDLE;
      endcase
    end
  end

  // Byte assembly and read mode tracking, LSB first
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_q <= '0;
      bit_q <= '0;
      rd_mode_q <= 1'b0;
    end else if (st_q == D_RST) begin
      bit_q <= '0;
      rd_mode_q <= 1'b0;
    end else if (rx_valid_o) begin
      byte_q <= cmd_d;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (cmd_d == swl_pkg::CMD_READ_PAD || cmd_d == swl_pkg::CMD_READ_PWR)
          rd_mode_q <= 1'b1;
        if (cmd_d == swl_pkg::CMD_CONVERT || cmd_d == swl_pkg::CMD_RECALL)
          rd_mode_q <= ~parasite_i;
      end
    end
  end
endmodule : swl_dev

// *** hdl/swl_host.sv ***
`timescale 1ns/1ps
module swl_host (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Async reset
  swl_link_if.host link, // Line side
  input wire logic req_i, // Operation request
  input wire logic [1:0] op_i, // Operation code
  input wire logic [7:0] wdata_i, // Byte to write
  input wire logic spu_req_i, // Want strong pullup after write
  input wire logic spu_off_i, // Drop strong pullup
  output logic ready_o, // Idle, accepts request unless strong pullup is on
  output logic done_o, // Operation done pulse
  output logic [7:0] rdata_o, // Byte read
  output logic present_o, // Presence seen
  output logic spu_o // Strong pullup enable
);
  typedef enum logic [2:0] {H_IDLE, H_RLOW, H_RWAIT, H_SLOT, H_REC} swl_hstate_type;
  swl_hstate_type st_q;
  logic [swl_pkg::CNT_W-1:0] cnt_q;
  logic line_s;
  logic [1:0] op_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic spu_pend_q;

  swl_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(link.line),
    .q_o(line_s)
  );

  // Sequencer for reset and slots
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      op_q <= swl_pkg::OP_RESET;
      sh_q <= '0;
      bit_q <= '0;
      link.host_pull <= 1'b0;
      ready_o <= 1'b1;
      done_o <= 1'b0;
      rdata_o <= '0;
      present_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        H_IDLE: begin
          link.host_pull <= 1'b0;
          if (req_i && ready_o && !spu_o) begin
            ready_o <= 1'b0;
            op_q <= op_i;
            sh_q <= wdata_i;
            bit_q <= '0;
            cnt_q <= '0;
            link.host_pull <= 1'b1;
            if (op_i == swl_pkg::OP_RESET) begin
              st_q <= H_RLOW;
              present_o <= 1'b0;
            end else st_q <= H_SLOT;
          end
        end
        H_RLOW: begin
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::RESET_LOW_CYC)) begin
            link.host_pull <= 1'b0;
            st_q <= H_RWAIT;
            cnt_q <= '0;
          end
        end
        H_RWAIT: begin
          // Watch for presence in receive mode
          if (!line_s && cnt_q > swl_pkg::CNT_W'(swl_pkg::REC_CYC)) present_o <= 1'b1;
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::PRES_WIN_CYC)) begin
            st_q <= H_IDLE;
            ready_o <= 1'b1;
            done_o <= 1'b1;
          end
        end
        H_SLOT: begin
          // Release point depends on slot kind
          if (op_q == swl_pkg::OP_READ) begin
            if (cnt_q == swl_pkg::CNT_W'(swl_pkg::RD_LOW_CYC)) link.host_pull <= 1'b0;
            if (cnt_q == swl_pkg::CNT_W'(swl_pkg::MST_SAMPLE_CYC))
              sh_q <= {line_s, sh_q[7:1]};
          end else if (sh_q[0] && cnt_q == swl_pkg::CNT_W'(swl_pkg::WR1_LOW_CYC)) begin
            link.host_pull <= 1'b0;
          end
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::SLOT_CYC)) begin
            link.host_pull <= 1'b0;
            if (op_q == swl_pkg::OP_WRITE) sh_q <= {1'b0, sh_q[7:1]};
            st_q <= H_REC;
            cnt_q <= '0;
          end
        end
        H_REC: begin
          if (cnt_q == swl_pkg::CNT_W'(swl_pkg::REC_CYC) && line_s) begin
            cnt_q <= '0;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= H_IDLE;
              ready_o <= 1'b1;
              done_o <= 1'b1;
              if (op_q == swl_pkg::OP_READ) rdata_o <= sh_q;
            end else begin
              st_q <= H_SLOT;
              link.host_pull <= 1'b1;
            end
          end else if (cnt_q == swl_pkg::CNT_W'(swl_pkg::REC_CYC)) begin
            cnt_q <= cnt_q;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Strong pullup after any write requested with spu_req_i
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spu_pend_q <= 1'b0;
      spu_o <= 1'b0;
    end else begin
      if (req_i && ready_o && !spu_o && op_i == swl_pkg::OP_WRITE && spu_req_i)
        spu_pend_q <= 1'b1;
      if (spu_pend_q && done_o) begin
        spu_pend_q <= 1'b0;
        spu_o <= 1'b1;
      end else if (spu_off_i) begin
        spu_o <= 1'b0;
      end
    end
  end
endmodule : swl_host

// *** testbench/swl_link_monitor.sv ***
`timescale 1ns/1ps
module swl_link_monitor (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic host_pull, // Host pulls low
  input wire logic dev_pull, // Device pulls low
  input wire logic line // Resolved line
);
  int hl_q;
  int dl_q;
  int hi_q;
  int sr_q;
  int lr_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Run lengths; idle line counts as long recovered
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hl_q <= 0;
      dl_q <= 0;
      hi_q <= 1000;
      sr_q <= 100000;
      lr_q <= 0;
    end else begin
      hl_q <= host_pull ? hl_q + 1 : 0;
      dl_q <= dev_pull ? dl_q + 1 : 0;
      hi_q <= line ? hi_q + 1 : 0;
      sr_q <= (host_pull && hl_q == 0) ? 0 : sr_q + 1;
      if (!host_pull && hl_q != 0) lr_q <= hl_q; // Last host low run
    end
  end
  // Host side timing
  chk_init_release: assert property (
    $fell(host_pull) && hl_q < 7500 |-> hl_q >= 125 && hl_q <= 1875)
    else $error("short host low pulse out of range");
  chk_zero_hold: assert property (
    $fell(host_pull) && hl_q > 1875 |-> hl_q >= 7500 && (hl_q < 50000 || hl_q >= 60000))
    else $error("long host low pulse out of range");
  chk_slot_recovery: assert property (
    $rose(host_pull) |-> hi_q >= 125 && sr_q >= 7625)
    else $error("slot started too early");
  // Device side timing
  chk_presence_wait: assert property (
    $rose(dev_pull) && !host_pull |-> lr_q >= 60000 && hi_q >= 1875 && hi_q <= 7500)
    else $error("device pull outside presence wait");
  chk_presence_len: assert property (
    $fell(dev_pull) && lr_q >= 60000 |-> dl_q >= 7500 && dl_q <= 30000)
    else $error("presence pulse length wrong");
  chk_reply_start: assert property (
    $rose(dev_pull) && host_pull |-> hl_q <= 16)
    else $error("read reply not tied to slot edge");
  chk_reply_release: assert property (
    $fell(dev_pull) && lr_q < 60000 |-> dl_q >= 1484 && dl_q < 7500)
    else $error("read zero hold wrong");
  chk_pull_width: assert property (
    $rose(dev_pull) |-> ##1 dev_pull [*8])
    else $error("device pull too short");
  cover property ($fell(dev_pull) && lr_q >= 60000);
  cover property ($fell(dev_pull) && lr_q < 60000);
  cover property ($fell(host_pull) && hl_q >= 7500 && hl_q < 50000);
endmodule : swl_link_monitor

// *** testbench/single_wire_slot_signaling_tb_top.sv ***
`timescale 1ns/1ps
module single_wire_slot_signaling_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [1:0] op_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic spu_req_i = 1'b0;
  logic spu_off_i = 1'b0;
  logic busy_i = 1'b0;
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  logic [7:0] pres_n = 8'h00;
  logic ready_o, done_o, h_pres, spu_o, tx_take_o, rx_valid_o, rx_bit_o, d_pres;
  logic [7:0] rdata_o;
  int bad_count = 0;
  int checked = 0;
  swl_link_if swl_link_if_inst ();
  swl_host swl_host_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(swl_link_if_inst),
    .req_i(req_i), .op_i(op_i), .wdata_i(wdata_i), .spu_req_i(spu_req_i),
    .spu_off_i(spu_off_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .present_o(h_pres), .spu_o(spu_o));
  swl_dev swl_dev_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(swl_link_if_inst),
    .busy_i(busy_i), .parasite_i(1'b0), .tx_bit_i(tx_q[0]), .tx_take_o(tx_take_o),
    .rx_valid_o(rx_valid_o), .rx_bit_o(rx_bit_o), .present_o(d_pres));
  swl_link_monitor swl_link_monitor_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .host_pull(swl_link_if_inst.host_pull), .dev_pull(swl_link_if_inst.dev_pull),
    .line(swl_link_if_inst.line));
  always #4 core_clk_i = ~core_clk_i;
  // Device user side: rotate out bits, collect received bits
  always @(posedge core_clk_i) begin
    if (tx_take_o) tx_q <= {tx_q[0], tx_q[7:1]};
    if (rx_valid_o) rx_q <= {rx_bit_o, rx_q[7:1]};
    if (d_pres) pres_n <= pres_n + 8'h01;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // One host operation, waits for its done pulse
  task automatic run_op(input logic [1:0] op, input logic [7:0] d, input logic spu);
    int n;
    @(negedge core_clk_i);
    op_i = op;
    wdata_i = d;
    spu_req_i = spu;
    req_i = 1'b1;
    @(negedge core_clk_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 120000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 120000) begin
      bad_count++;
      close_out();
    end
  endtask : run_op
  // Main sequence
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    run_op(swl_pkg::OP_RESET, 8'h00, 1'b0);
    cmp("host presence", 8'h01, {7'h00, h_pres});
    cmp("device presence", 8'h01, pres_n);
    cmp("host ready", 8'h01, {7'h00, ready_o});
    tx_q = 8'ha5;
    run_op(swl_pkg::OP_WRITE, swl_pkg::CMD_READ_PAD, 1'b0);
    cmp("device rx", swl_pkg::CMD_READ_PAD, rx_q);
    run_op(swl_pkg::OP_READ, 8'h00, 1'b0);
    cmp("read data", 8'ha5, rdata_o);
    run_op(swl_pkg::OP_RESET, 8'h00, 1'b0);
    cmp("device presence", 8'h02, pres_n);
    busy_i = 1'b1;
    tx_q = 8'hff;
    run_op(swl_pkg::OP_WRITE, swl_pkg::CMD_CONVERT, 1'b1);
    cmp("device rx", swl_pkg::CMD_CONVERT, rx_q);
    repeat (1250) @(negedge core_clk_i);
    cmp("strong pullup", 8'h01, {7'h00, spu_o});
    spu_off_i = 1'b1;
    @(negedge core_clk_i);
    spu_off_i = 1'b0;
    @(negedge core_clk_i);
    cmp("strong pullup", 8'h00, {7'h00, spu_o});
    run_op(swl_pkg::OP_READ, 8'h00, 1'b0);
    cmp("poll busy", 8'h00, rdata_o);
    busy_i = 1'b0;
    run_op(swl_pkg::OP_READ, 8'h00, 1'b0);
    cmp("poll done", 8'hff, rdata_o);
    close_out();
  end
endmodule : single_wire_slot_signaling_tb_top
